/* pkg/pwci_pkg.sv */
// Constants, types and register map of the password-protected command interpreter.
// Assumes a Modbus front end that turns holding-register accesses into single-word
// read and write strobes and marks the end of each multiple-register write frame.
// Overview of operation
// - Four user profiles, each with own password
// - Factory passwords are 0000, 1111, 2222, 3333
// - Password is four letters or digits only
// - Own or administrator password replaces a password
// - Intrusive command needs a matching profile password
// - Non-intrusive commands run without any check
// - Intrusive needs open lock or configuration unlock
// - Each command picked by unique code
// - Status reads 0x0003 while command executes
// - Last command code shown after execution
// - Status low byte zero on success, else error
// - Wrong password reports error code 1
// - New command aborts the unfinished one
// - Failure puts module address in high byte
// - Code write arms, frame end triggers execution
`default_nettype none
package pwci_pkg;

  // Register numbers as seen on the holding-register port
  localparam logic [15:0] REG_CMD_CODE  = 16'h1F40;
  localparam logic [15:0] REG_LAST_CODE = 16'h1F54;
  localparam logic [15:0] REG_STATUS    = 16'h1F55;
  localparam int          BUF_WORDS     = 16;

  // Word positions inside the command buffer
  localparam logic [3:0] IDX_CODE     = 4'h0;
  localparam logic [3:0] IDX_PW_HI    = 4'h4;
  localparam logic [3:0] IDX_PW_LO    = 4'h5;
  localparam logic [3:0] IDX_TARGET   = 4'h6;
  localparam logic [3:0] IDX_NEWPW_HI = 4'h7;
  localparam logic [3:0] IDX_NEWPW_LO = 4'h8;

  // Command codes
  localparam logic [15:0] CMD_OPEN    = 16'h0388;
  localparam logic [15:0] CMD_CLOSE   = 16'h0389;
  localparam logic [15:0] CMD_SET_PW  = 16'h0300;
  localparam logic [15:0] CMD_PING    = 16'h0301;

  // Profiles: bit 0 administrator, 1 services, 2 engineer, 3 operator
  localparam int          NUM_PROFILES = 4;
  localparam logic [1:0]  PROF_ADMIN   = 2'h0;
  localparam logic [1:0]  PROF_MAX     = 2'h3;
  localparam logic [3:0]  PROF_SWITCH  = 4'h9;
  localparam logic [3:0][31:0] PW_DEFAULT = {32'h33333333, 32'h32323232,
                                             32'h31313131, 32'h30303030};

  // Status and completion codes
  localparam logic [15:0] STATUS_BUSY = 16'h0003;
  localparam logic [15:0] STATUS_OK   = 16'h0000;
  localparam logic [7:0]  ERR_OK      = 8'h00;
  localparam logic [7:0]  ERR_RIGHTS  = 8'h01;
  localparam logic [7:0]  ERR_ACCESS  = 8'h02;
  localparam logic [7:0]  ERR_WRITE   = 8'h04;

  // Execution time
  localparam int EXEC_TIME_NS  = 1000;
  localparam int CLK_PERIOD_NS = 100;
  localparam int EXEC_CYCLES   = (EXEC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] CNT_LAST = 8'h01;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ARMED = 2'b01,
    ST_CHECK = 2'b10,
    ST_EXEC  = 2'b11
  } pwci_state_type;

endpackage
`default_nettype wire

/* src/pwci_pw_check.sv */
// Password comparison against all profiles and character check of a new password.
// Purely combinational; the caller registers whatever it decides from it.
`timescale 1ns/1ps
`default_nettype none
module pwci_pw_check (
  input  wire logic [3:0][31:0] pw_table_in,
  input  wire logic [31:0]      supplied_in,
  input  wire logic [31:0]      new_pw_in,
  output logic      [3:0]       match_out,
  output logic                  new_ok_out
);

  // Accept only 0-9, a-z and A-Z
  function automatic logic char_ok(input logic [7:0] c);
    return (c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h5A) ||
           (c >= 8'h61 && c <= 8'h7A);
  endfunction

  // Exact four-byte compare keeps the check case-sensitive
  always_comb begin
    for (int i = 0; i < pwci_pkg::NUM_PROFILES; i++) begin
      match_out[i] = (pw_table_in[i] == supplied_in);
    end
  end

  // All four characters must pass; length is fixed by the word pair
  always_comb begin
    new_ok_out = char_ok(new_pw_in[31:24]) && char_ok(new_pw_in[23:16]) &&
                 char_ok(new_pw_in[15:8]) && char_ok(new_pw_in[7:0]);
  end

endmodule // pwci_pw_check
`default_nettype wire

/* src/pwci_top.sv */
// Command interpreter: command buffer, profile passwords, lock and password checks,
// status and last-code registers.
// Assumes synchronous single-word register strobes and a frame-end pulse from the
// Modbus front end; the lock input is already debounced.
`timescale 1ns/1ps
`default_nettype none
module pwci_top #(
  parameter int         EXEC_CYCLES = pwci_pkg::EXEC_CYCLES,
  parameter logic [7:0] MODULE_ADDR = 8'h12  // Arbitrary value
) (
  input  wire logic        CLK_IN,
  input  wire logic        ARST_N_IN,
  input  wire logic        REG_WR_IN,
  input  wire logic        REG_RD_IN,
  input  wire logic [15:0] REG_ADDR_IN,
  input  wire logic [15:0] REG_WDATA_IN,
  input  wire logic        FRAME_END_IN,
  input  wire logic        LOCK_OPEN_IN,
  input  wire logic        INTR_UNLOCK_IN,
  output logic      [15:0] REG_RDATA_OUT,
  output logic             REG_RVALID_OUT,
  output logic             BUSY_OUT,
  output logic             OPEN_CMD_OUT,
  output logic             CLOSE_CMD_OUT
);

  // Counter is 8 bits wide
  if (EXEC_CYCLES < 1 || EXEC_CYCLES > 255) begin : g_bad_exec
    $error("EXEC_CYCLES must lie between 1 and 255");
  end

  typedef struct packed {
    pwci_pkg::pwci_state_type st;
    logic [15:0][15:0]        cbuf;
    logic [3:0][31:0]         pw;
    logic [15:0]              last;
    logic [15:0]              status;
    logic [7:0]               cnt;
    logic [7:0]               res_err;
    logic [1:0]               ptgt;
    logic [31:0]              npw;
    logic [15:0]              rdata;
    logic                     rvalid;
    logic                     busy;
    logic                     open;
    logic                     close;
  } pwci_regs_type;

  pwci_regs_type q_ff;
  pwci_regs_type nxt_q;
  logic          rst_s1_ff;
  logic          rst_s2_ff;
  wire logic     rst_n = rst_s2_ff;

  // Reset release through two flops so that all state leaves reset on one edge
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      rst_s1_ff <= 1'b0;
      rst_s2_ff <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_s2_ff <= rst_s1_ff;
    end
  end

  // Command table lookups
  function automatic logic cmd_known(input logic [15:0] c);
    return c == pwci_pkg::CMD_OPEN || c == pwci_pkg::CMD_CLOSE ||
           c == pwci_pkg::CMD_SET_PW || c == pwci_pkg::CMD_PING;
  endfunction

  function automatic logic cmd_intrusive(input logic [15:0] c);
    return c == pwci_pkg::CMD_OPEN || c == pwci_pkg::CMD_CLOSE ||
           c == pwci_pkg::CMD_SET_PW;
  endfunction

  function automatic logic [3:0] cmd_profiles(input logic [15:0] c);
    return (c == pwci_pkg::CMD_SET_PW) ? 4'hF : pwci_pkg::PROF_SWITCH;
  endfunction

  // Register decode
  wire logic [15:0] buf_off  = REG_ADDR_IN - pwci_pkg::REG_CMD_CODE;
  wire logic        buf_hit  = buf_off < 16'(pwci_pkg::BUF_WORDS);
  wire logic        code_wr  = REG_WR_IN && (REG_ADDR_IN == pwci_pkg::REG_CMD_CODE);
  wire logic [15:0] cur_code = q_ff.cbuf[pwci_pkg::IDX_CODE];
  wire logic [15:0] tgt_word = q_ff.cbuf[pwci_pkg::IDX_TARGET];
  wire logic [1:0]  tgt      = tgt_word[1:0];
  wire logic        unlocked = LOCK_OPEN_IN || INTR_UNLOCK_IN;
  logic [3:0]       match;
  logic             new_ok;

  pwci_pw_check u_check (
    .pw_table_in (q_ff.pw),
    .supplied_in ({q_ff.cbuf[pwci_pkg::IDX_PW_HI], q_ff.cbuf[pwci_pkg::IDX_PW_LO]}),
    .new_pw_in   ({q_ff.cbuf[pwci_pkg::IDX_NEWPW_HI], q_ff.cbuf[pwci_pkg::IDX_NEWPW_LO]}),
    .match_out   (match),
    .new_ok_out  (new_ok)
  );

  // Verdict; hardware lock is tested before any password
  logic [7:0] verdict;
  always_comb begin
    if (!cmd_known(cur_code)) begin
      verdict = pwci_pkg::ERR_WRITE;
    end else if (!cmd_intrusive(cur_code)) begin
      verdict = pwci_pkg::ERR_OK;
    end else if (!unlocked) begin
      verdict = pwci_pkg::ERR_ACCESS;
    end else if (cur_code == pwci_pkg::CMD_SET_PW) begin
      if (tgt_word > 16'(pwci_pkg::PROF_MAX)) begin
        verdict = pwci_pkg::ERR_WRITE;
      end else if (!(match[tgt] || match[pwci_pkg::PROF_ADMIN])) begin
        verdict = pwci_pkg::ERR_RIGHTS;
      end else if (!new_ok) begin
        verdict = pwci_pkg::ERR_WRITE;
      end else begin
        verdict = pwci_pkg::ERR_OK;
      end
    end else if ((match & cmd_profiles(cur_code)) == 4'h0) begin
      verdict = pwci_pkg::ERR_RIGHTS;
    end else begin
      verdict = pwci_pkg::ERR_OK;
    end
  end

  // Next-state logic for the whole block
  always_comb begin
    nxt_q        = q_ff;
    nxt_q.rvalid = 1'b0;
    nxt_q.open   = 1'b0;
    nxt_q.close  = 1'b0;
    // Buffer words stay writable while busy so a resent frame lands whole
    if (REG_WR_IN && buf_hit) begin
      nxt_q.cbuf[buf_off[3:0]] = REG_WDATA_IN;
    end
    if (REG_RD_IN) begin
      nxt_q.rvalid = 1'b1;
      if (buf_hit) begin
        nxt_q.rdata = q_ff.cbuf[buf_off[3:0]];
      end else if (REG_ADDR_IN == pwci_pkg::REG_LAST_CODE) begin
        nxt_q.rdata = q_ff.last;
      end else if (REG_ADDR_IN == pwci_pkg::REG_STATUS) begin
        nxt_q.rdata = q_ff.status;
      end else begin
        nxt_q.rdata = 16'h0000;
      end
    end
    case (q_ff.st)
      pwci_pkg::ST_ARMED: begin
        if (FRAME_END_IN) begin
          nxt_q.st = pwci_pkg::ST_CHECK;
        end
      end
      pwci_pkg::ST_CHECK: begin
        nxt_q.res_err = verdict;
        // Frozen with the verdict so later buffer writes cannot widen the rights
        nxt_q.ptgt    = tgt;
        nxt_q.npw     = {q_ff.cbuf[pwci_pkg::IDX_NEWPW_HI],
                         q_ff.cbuf[pwci_pkg::IDX_NEWPW_LO]};
        nxt_q.cnt     = EXEC_CYCLES[7:0];
        nxt_q.st      = pwci_pkg::ST_EXEC;
      end
      pwci_pkg::ST_EXEC: begin
        if (q_ff.cnt == pwci_pkg::CNT_LAST) begin
          nxt_q.st   = pwci_pkg::ST_IDLE;
          nxt_q.busy = 1'b0;
          nxt_q.last = cur_code;
          // Effects happen only on a clean verdict
          if (q_ff.res_err == pwci_pkg::ERR_OK) begin
            nxt_q.status = pwci_pkg::STATUS_OK;
            nxt_q.open   = cur_code == pwci_pkg::CMD_OPEN;
            nxt_q.close  = cur_code == pwci_pkg::CMD_CLOSE;
            if (cur_code == pwci_pkg::CMD_SET_PW) begin
              nxt_q.pw[q_ff.ptgt] = q_ff.npw;
            end
          end else begin
            nxt_q.status = {MODULE_ADDR, q_ff.res_err};
          end
        end else begin
          nxt_q.cnt = q_ff.cnt - pwci_pkg::CNT_LAST;
        end
      end
      default: begin
      end
    endcase
    // A code write restarts the state machine, status and busy flag and keeps passwords and last code, dropping any unfinished command
    if (code_wr) begin
      nxt_q.st     = FRAME_END_IN ? pwci_pkg::ST_CHECK : pwci_pkg::ST_ARMED;
      nxt_q.status = pwci_pkg::STATUS_BUSY;
      nxt_q.busy   = 1'b1;
      nxt_q.open   = 1'b0;
      nxt_q.close  = 1'b0;
      nxt_q.pw     = q_ff.pw;
      nxt_q.last   = q_ff.last;
    end
  end

  // State register; passwords come up at factory values
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      q_ff         <= '0;
      q_ff.st      <= pwci_pkg::ST_IDLE;
      q_ff.pw      <= pwci_pkg::PW_DEFAULT;
      q_ff.status  <= pwci_pkg::STATUS_OK;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign REG_RDATA_OUT  = q_ff.rdata;
  assign REG_RVALID_OUT = q_ff.rvalid;
  assign BUSY_OUT       = q_ff.busy;
  assign OPEN_CMD_OUT   = q_ff.open;
  assign CLOSE_CMD_OUT  = q_ff.close;

  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!rst_n);

  a_busy_status: assert property (
    q_ff.st != pwci_pkg::ST_IDLE |-> q_ff.status == pwci_pkg::STATUS_BUSY && BUSY_OUT)
    else $error("status not busy during execution");

  a_code_trigger: assert property (
    code_wr |=> q_ff.st == pwci_pkg::ST_ARMED || q_ff.st == pwci_pkg::ST_CHECK)
    else $error("code write did not arm the command");

  a_last_code: assert property (
    $fell(BUSY_OUT) |-> q_ff.last == q_ff.cbuf[pwci_pkg::IDX_CODE])
    else $error("last code differs from executed code");

  a_ok_status: assert property (
    $rose(OPEN_CMD_OUT) |-> q_ff.status == pwci_pkg::STATUS_OK &&
                            q_ff.last == pwci_pkg::CMD_OPEN)
    else $error("open pulse without success status");

  a_lock_refuse: assert property (
    q_ff.st == pwci_pkg::ST_CHECK && cmd_intrusive(cur_code) && !unlocked
    |=> q_ff.res_err == pwci_pkg::ERR_ACCESS)
    else $error("locked intrusive command not refused");

  a_rights_err: assert property (
    q_ff.st == pwci_pkg::ST_CHECK && unlocked && cur_code == pwci_pkg::CMD_OPEN &&
    (match & pwci_pkg::PROF_SWITCH) == 4'h0 |=> q_ff.res_err == pwci_pkg::ERR_RIGHTS)
    else $error("wrong password not reported as rights error");

  a_free_cmd: assert property (
    q_ff.st == pwci_pkg::ST_CHECK && cur_code == pwci_pkg::CMD_PING
    |=> q_ff.res_err == pwci_pkg::ERR_OK)
    else $error("non-intrusive command refused");

  a_fail_module: assert property (
    $fell(BUSY_OUT) && q_ff.status[7:0] != pwci_pkg::ERR_OK
    |-> q_ff.status[15:8] == MODULE_ADDR)
    else $error("failure status lacks module address");

  a_refused_inert: assert property (
    q_ff.st == pwci_pkg::ST_EXEC && q_ff.res_err != pwci_pkg::ERR_OK
    |=> !OPEN_CMD_OUT && !CLOSE_CMD_OUT && $stable(q_ff.pw))
    else $error("refused command changed protected state");

  a_abort_new: assert property (
    code_wr && q_ff.st == pwci_pkg::ST_EXEC |=> !OPEN_CMD_OUT && BUSY_OUT)
    else $error("earlier command not aborted");

endmodule // pwci_top
`default_nettype wire

/* dv/pwci_mb_master.sv */
// Behavioural Modbus master: turns holding-register accesses into single-word strobes.
// Assumes the bench calls its tasks one at a time, from one process only.
`timescale 1ns/1ps
`default_nettype none
module pwci_mb_master (
  input  wire logic        clk_in,
  input  wire logic [15:0] rdata_in,
  output logic             wr_out,
  output logic             rd_out,
  output logic      [15:0] addr_out,
  output logic      [15:0] wdata_out,
  output logic             frame_end_out
);
  // Idle lines carry the inverse of the last value, so stale data never looks valid
  initial begin
    wr_out = 1'h0;
    rd_out = 1'h0;
    addr_out = 16'hFFFF;
    wdata_out = 16'hFFFF;
    frame_end_out = 1'h0;
  end

  // One word per strobe, held until the sampling edge
  task automatic wr_word(input logic [15:0] a, input logic [15:0] d, input logic last);
    @(posedge clk_in);
    wr_out <= 1'h1;
    addr_out <= a;
    wdata_out <= d;
    frame_end_out <= last;
    @(posedge clk_in);
    wr_out <= 1'h0;
    frame_end_out <= 1'h0;
    addr_out <= ~a;
    wdata_out <= ~d;
  endtask

  // Read data is registered, so it is taken once the edge after the strobe has settled
  task automatic rd_word(input logic [15:0] a, output logic [15:0] d);
    @(posedge clk_in);
    rd_out <= 1'h1;
    addr_out <= a;
    @(posedge clk_in);
    rd_out <= 1'h0;
    addr_out <= ~a;
    #1;
    d = rdata_in;
  endtask

  // Buffer words 0 to 8 in one frame starting at the code word; frame end marks the last word
  task automatic send_cmd(input logic [15:0] code, input logic [31:0] pw,
                          input logic [15:0] tgt, input logic [31:0] npw);
    logic [8:0][15:0] w;
    w = {npw[15:0], npw[31:16], tgt, pw[15:0], pw[31:16], 16'h0000, 16'h0000, 16'h0000, code};
    for (int i = 0; i < 9; i++) begin
      wr_word(16'h1F40 + 16'(i), w[i], i == 8);
    end
  endtask

  // Poll status until it leaves busy; bounded so a stuck device cannot hang the run
  task automatic poll(output logic [15:0] st, output logic ok);
    ok = 1'h0;
    for (int n = 0; n < 100 && !ok; n++) begin
      rd_word(16'h1F55, st);
      ok = (st !== 16'h0003);
    end
  endtask
endmodule // pwci_mb_master
`default_nettype wire

/* dv/test_pwci_top.sv */
// Self-checking bench of the command interpreter: commands, rights, lock and abort.
// Assumes the master model in pwci_mb_master and the design package.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_pwci_top;
  localparam logic [7:0] MOD_ADDR = 8'h12; // Arbitrary value
  logic        clk_in;
  logic        arst_n;
  logic        lock_open;
  logic        intr_unlock;
  logic        wr;
  logic        rd;
  logic        frame_end;
  logic [15:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic [15:0] v;
  logic        busy;
  logic        rvalid;
  logic        open_p;
  logic        close_p;
  int          n_open = 0;
  int          n_close = 0;
  int          n_mismatch = 0;
  int          tests_run = 0;

  pwci_top #(.EXEC_CYCLES(20), .MODULE_ADDR(MOD_ADDR)) dut (
    .CLK_IN(clk_in), .ARST_N_IN(arst_n), .REG_WR_IN(wr), .REG_RD_IN(rd),
    .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata), .FRAME_END_IN(frame_end),
    .LOCK_OPEN_IN(lock_open), .INTR_UNLOCK_IN(intr_unlock), .REG_RDATA_OUT(rdata),
    .REG_RVALID_OUT(rvalid), .BUSY_OUT(busy), .OPEN_CMD_OUT(open_p), .CLOSE_CMD_OUT(close_p));

  pwci_mb_master m (.clk_in(clk_in), .rdata_in(rdata), .wr_out(wr), .rd_out(rd),
    .addr_out(addr), .wdata_out(wdata), .frame_end_out(frame_end));

  initial begin
    clk_in = 1'h0;
    forever #50 clk_in = ~clk_in;
  end

  // Count breaker pulses; refused commands must leave these untouched
  always @(posedge clk_in) begin
    if (open_p === 1'h1) n_open++;
    if (close_p === 1'h1) n_close++;
  end

  task automatic wrap_up;
    if (n_mismatch == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Full command cycle: busy seen first, then completion code and echoed code
  task automatic run(input logic [15:0] code, input logic [31:0] pw, input logic [15:0] tgt,
                     input logic [31:0] npw, input logic [7:0] err);
    logic ok;
    m.send_cmd(code, pw, tgt, npw);
    m.rd_word(16'h1F55, v);
    `CHK(v, 16'h0003)
    `CHK(busy, 1'h1)
    m.poll(v, ok);
    if (!ok) begin
      n_mismatch++;
      wrap_up();
    end
    `CHK(v, (err == 8'h00) ? 16'h0000 : {MOD_ADDR, err})
    `CHK(busy, 1'h0)
    m.rd_word(16'h1F54, v);
    `CHK(v, code)
  endtask

  // Watchdog against a hang anywhere in the sequence
  initial begin
    repeat (50000) @(posedge clk_in);
    n_mismatch++;
    wrap_up();
  end

  initial begin
    arst_n = 1'h0;
    lock_open = 1'h0;
    intr_unlock = 1'h0;
    repeat (5) @(posedge clk_in);
    arst_n <= 1'h1;
    repeat (3) @(posedge clk_in);
    m.rd_word(16'h1F55, v);
    `CHK(v, 16'h0000)
    `CHK(rvalid, 1'h1)
    m.rd_word(16'h1F60, v);
    `CHK(v, 16'h0000)
    run(pwci_pkg::CMD_PING, 32'h0, 16'h0, 32'h0, 8'h00);
    run(pwci_pkg::CMD_OPEN, 32'h30303030, 16'h0, 32'h0, 8'h02);
    @(posedge clk_in);
    lock_open <= 1'h1;
    run(pwci_pkg::CMD_OPEN, 32'h30303031, 16'h0, 32'h0, 8'h01);
    run(pwci_pkg::CMD_CLOSE, 32'h31313131, 16'h0, 32'h0, 8'h01);
    `CHK(n_open + n_close, 0)
    @(posedge clk_in);
    lock_open <= 1'h0;
    intr_unlock <= 1'h1;
    run(pwci_pkg::CMD_OPEN, 32'h33333333, 16'h0, 32'h0, 8'h00);
    run(pwci_pkg::CMD_CLOSE, 32'h30303030, 16'h0, 32'h0, 8'h00);
    `CHK(n_open + n_close, 2)
    // Password changes: own, stale, foreign, administrator, illegal character
    run(pwci_pkg::CMD_SET_PW, 32'h31313131, 16'h1, 32'h4162397A, 8'h00);
    run(pwci_pkg::CMD_SET_PW, 32'h31313131, 16'h1, 32'h31313131, 8'h01);
    run(pwci_pkg::CMD_SET_PW, 32'h32323232, 16'h3, 32'h78593132, 8'h01);
    run(pwci_pkg::CMD_OPEN, 32'h33333333, 16'h0, 32'h0, 8'h00);
    run(pwci_pkg::CMD_SET_PW, 32'h30303030, 16'h3, 32'h78593132, 8'h00);
    run(pwci_pkg::CMD_SET_PW, 32'h30303030, 16'h2, 32'h61622D31, 8'h04);
    run(pwci_pkg::CMD_SET_PW, 32'h30303030, 16'h4, 32'h41414141, 8'h04);
    run(pwci_pkg::CMD_OPEN, 32'h33333333, 16'h0, 32'h0, 8'h01);
    run(pwci_pkg::CMD_OPEN, 32'h78593132, 16'h0, 32'h0, 8'h00);
    run(16'h0123, 32'h30303030, 16'h0, 32'h0, 8'h04);
    // A new command before completion must cancel the pending open
    m.send_cmd(pwci_pkg::CMD_OPEN, 32'h78593132, 16'h0, 32'h0);
    m.wr_word(16'h1F40, pwci_pkg::CMD_PING, 1'h1);
    run(pwci_pkg::CMD_PING, 32'h0, 16'h0, 32'h0, 8'h00);
    `CHK(n_open, 3)
    wrap_up();
  end
endmodule // test_pwci_top
`default_nettype wire
